//--- src/ogs_defs.vh
/*
  Offsets, fields, reset values, limits and codes of the output setup block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef OGS_DEFS_VH
`define OGS_DEFS_VH

// Register byte offsets on the APB bus
`define OGS_ADDR_CTRL    8'h00
`define OGS_ADDR_FUNC    8'h04
`define OGS_ADDR_DUTY    8'h08
`define OGS_ADDR_SYMM    8'h0C
`define OGS_ADDR_AMPL    8'h10
`define OGS_ADDR_OFFS    8'h14
`define OGS_ADDR_UNITS   8'h18
`define OGS_ADDR_CMD     8'h1C
`define OGS_ADDR_STATUS  8'h20

// CTRL fields
`define OGS_CTRL_OUT_EN  0
`define OGS_CTRL_INVERT  1
`define OGS_CTRL_SYNC_EN 2
`define OGS_CTRL_HIZ     3
`define OGS_CTRL_MARKER  4
`define OGS_CTRL_RNG_LO  5
`define OGS_CTRL_RNG_HI  6

// FUNC fields
`define OGS_FUNC_LO      0
`define OGS_FUNC_HI      2
`define OGS_MODE_LO      4
`define OGS_MODE_HI      6

// CMD bits (write only, self clearing)
`define OGS_CMD_APPLY    0
`define OGS_CMD_RRESET   1
`define OGS_CMD_ONCE     2

// STATUS bits
`define OGS_ST_OUT_ON    0
`define OGS_ST_FREQ_HI   1
`define OGS_ST_SYNC      2
`define OGS_ST_HOLD      3
`define OGS_ST_ERR_DBM   8
`define OGS_ST_ERR_OVL   9

// Waveform functions
`define OGS_FN_SINE      3'h0
`define OGS_FN_SQUARE    3'h1
`define OGS_FN_RAMP      3'h2
`define OGS_FN_PULSE     3'h3
`define OGS_FN_ARB       3'h4
`define OGS_FN_DC        3'h5
`define OGS_FN_NOISE     3'h6

// Operating modes
`define OGS_MD_CONT      3'h0
`define OGS_MD_MOD_INT   3'h1
`define OGS_MD_MOD_EXT   3'h2
`define OGS_MD_FSK       3'h3
`define OGS_MD_SWEEP     3'h4
`define OGS_MD_BURST_TRG 3'h5
`define OGS_MD_BURST_INF 3'h6
`define OGS_MD_BURST_GAT 3'h7

// Autorange modes
`define OGS_RNG_OFF      2'h0
`define OGS_RNG_ON       2'h1
`define OGS_RNG_ONCE     2'h2

// Amplitude units
`define OGS_UNIT_VPP     2'h0
`define OGS_UNIT_VRMS    2'h1
`define OGS_UNIT_DBM     2'h2

// Percent limits and defaults
`define OGS_DUTY_MIN_LO  7'h14
`define OGS_DUTY_MAX_LO  7'h50
`define OGS_DUTY_MIN_HI  7'h28
`define OGS_DUTY_MAX_HI  7'h3C
`define OGS_DUTY_RST     7'h32
`define OGS_SYMM_RST     7'h64
`define OGS_SYMM_MAX     7'h64

// Level defaults, amplitude in mVpp into 50 ohms, offset in mV
`define OGS_AMPL_RST     16'h0064
`define OGS_OFFS_RST     16'h0000

`endif

//--- src/ogs_sync_gen.v
/*
  Sync pin generator: picks the sync source from function and mode.
  Assumes pclk-synchronous pulses and levels taken before polarity inversion.
*/
`timescale 1ns/1ns
`include "ogs_defs.vh"

module ogs_sync_gen (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  input  wire       sync_en,
  input  wire       marker_en,
  input  wire [2:0] func,
  input  wire [2:0] mode,
  input  wire       carrier_above,
  input  wire       arb_first,
  input  wire       arb_half,
  input  wire       mod_half,
  input  wire       fsk_hop,
  input  wire       sweep_start,
  input  wire       sweep_mid,
  input  wire       marker_hit,
  input  wire       burst_start,
  input  wire       burst_done,
  input  wire       gate_in,
  input  wire       cycle_end,
  output reg        sync_out
);

  reg  arb_flag;
  reg  sweep_flag;
  reg  burst_flag;
  reg  gate_flag;
  reg  next_sync;
  wire sweep_fall;
  wire carrier_sync;
  wire no_sync_fn;

  assign sweep_fall   = marker_en ? marker_hit : sweep_mid;                      // [RULE_20]
  assign no_sync_fn   = (func == `OGS_FN_DC) || (func == `OGS_FN_NOISE);         // [RULE_14]
  // Polarity never reaches here, so sync is never inverted
  assign carrier_sync = (func == `OGS_FN_ARB) ? arb_flag : carrier_above;        // [RULE_13]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_flag   <= 1'b0;
      sweep_flag <= 1'b0;
      burst_flag <= 1'b0;
      gate_flag  <= 1'b0;
      sync_out   <= 1'b0;
    end else if (ce) begin
      // Set wins over clear in every flag
      arb_flag   <= arb_first | (arb_flag & ~arb_half);                         // [RULE_17]
      sweep_flag <= sweep_start | (sweep_flag & ~sweep_fall);                   // [RULE_20]
      burst_flag <= burst_start | (burst_flag & ~burst_done);                   // [RULE_21]
      // Gate fall waits for the cycle end
      gate_flag  <= gate_in | (gate_flag & ~cycle_end);                         // [RULE_22]
      sync_out   <= next_sync;
    end
  end

  always @* begin
    next_sync = 1'b0;
    if (mode == `OGS_MD_SWEEP && marker_en) begin
      next_sync = sweep_flag;                                                   // [RULE_15]
    end else if (!sync_en || no_sync_fn) begin
      next_sync = 1'b0;                                                         // [RULE_14]
    end else begin
      case (mode)
        `OGS_MD_CONT:      next_sync = carrier_sync;                            // [RULE_16]
        `OGS_MD_MOD_INT:   next_sync = mod_half;                                // [RULE_18]
        `OGS_MD_MOD_EXT:   next_sync = carrier_sync;                            // [RULE_18]
        `OGS_MD_FSK:       next_sync = fsk_hop;                                 // [RULE_19]
        `OGS_MD_SWEEP:     next_sync = sweep_flag;                              // [RULE_20]
        `OGS_MD_BURST_TRG: next_sync = burst_flag;                              // [RULE_21]
        `OGS_MD_BURST_INF: next_sync = carrier_sync;                            // [RULE_21]
        `OGS_MD_BURST_GAT: next_sync = gate_flag;                               // [RULE_22]
        default:           next_sync = 1'b0;
      endcase
    end
  end

endmodule // ogs_sync_gen

//--- src/ogs_output_setup.v
/*
  Output-stage setup and sync generation: APB register file holding load
  termination, square duty, ramp symmetry, autorange, output enable, polarity,
  displayed levels and units, plus the sync pin generator.
  Assumes one pclk domain, synchronous inputs, and an outside store
  that keeps term_hiz and sync_en across power loss.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
// Operation
// [RULE_01] Termination setting kept in non-volatile storage
// [RULE_02] Termination change doubles or halves levels
// [RULE_03] High impedance refuses dBm, converts to Vpp
// [RULE_04] Duty 20-80 percent, 40-60 above 10 MHz
// [RULE_05] Duty volatile, resets to 50, retained
// [RULE_06] Frequency rise clamps duty to new maximum
// [RULE_07] Modulating square fixed 50, duty carrier-only
// [RULE_08] Apply forces duty, symmetry, autorange, output on
// [RULE_09] Symmetry volatile, resets to 100, carrier-only
// [RULE_10] Autorange default on, hold when off, once
// [RULE_11] Output off at power-up, overload forces off
// [RULE_12] Inversion about offset, normal default
// [RULE_13] Sync never inverted with the waveform
// [RULE_14] Sync enable non-volatile, low when disabled
// [RULE_15] Sweep marker overrides the sync enable
// [RULE_16] Sine, ramp, pulse, square sync above offset
// [RULE_17] Arbitrary sync rises on first point
// [RULE_18] Internal modulation sync follows modulating half
// [RULE_19] FSK sync high on hop transition
// [RULE_20] Sweep sync: start high, mid or marker low
// [RULE_21] Triggered burst sync spans the cycle count
// [RULE_22] Gated burst sync follows gate, delayed fall
`timescale 1ns/1ns
`include "ogs_defs.vh"

module ogs_output_setup (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        nv_term_hiz_in,
  input  wire        nv_sync_en_in,
  input  wire        freq_high,
  input  wire        overload,
  input  wire        carrier_above,
  input  wire        arb_first,
  input  wire        arb_half,
  input  wire        mod_half,
  input  wire        fsk_hop,
  input  wire        sweep_start,
  input  wire        sweep_mid,
  input  wire        marker_hit,
  input  wire        burst_start,
  input  wire        burst_done,
  input  wire        gate_in,
  input  wire        cycle_end,
  output reg         output_on,
  output reg         output_led,
  output reg         polarity_inv,
  output reg         term_hiz,
  output reg         sync_en,
  output reg  [6:0]  wave_duty,
  output reg  [6:0]  wave_symm,
  output reg  [6:0]  mod_src_duty,
  output reg  [6:0]  mod_src_symm,
  output reg  [15:0] ampl_disp,
  output reg  [15:0] offs_disp,
  output reg  [1:0]  units,
  output reg         range_auto,
  output reg         range_select,
  output wire        sync_out
);

  localparam ST_BOOT = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state;
  reg        out_en;
  reg        marker_en;
  reg [1:0]  range_mode;
  reg [2:0]  func;
  reg [2:0]  mode;
  reg [6:0]  duty;
  reg [6:0]  symm;
  reg        freq_high_d;
  reg        err_dbm;
  reg        err_ovl;
  reg [31:0] rd_word;
  reg        mapped;
  reg        set_dbm;

  wire setup   = psel & ~penable;
  wire wr      = psel & penable & pready & pwrite;
  wire wr_ctrl = wr && (paddr == `OGS_ADDR_CTRL);
  wire wr_func = wr && (paddr == `OGS_ADDR_FUNC);
  wire wr_duty = wr && (paddr == `OGS_ADDR_DUTY);
  wire wr_symm = wr && (paddr == `OGS_ADDR_SYMM);
  wire wr_ampl = wr && (paddr == `OGS_ADDR_AMPL);
  wire wr_offs = wr && (paddr == `OGS_ADDR_OFFS);
  wire wr_unit = wr && (paddr == `OGS_ADDR_UNITS);
  wire wr_cmd  = wr && (paddr == `OGS_ADDR_CMD);
  wire wr_stat = wr && (paddr == `OGS_ADDR_STATUS);
  wire apply   = wr_cmd & pwdata[`OGS_CMD_APPLY];
  wire rreset  = wr_cmd & pwdata[`OGS_CMD_RRESET];
  wire once    = wr_cmd & pwdata[`OGS_CMD_ONCE];
  wire new_hiz = pwdata[`OGS_CTRL_HIZ];
  wire hiz_chg = wr_ctrl && (new_hiz != term_hiz);
  wire fh_rise = freq_high & ~freq_high_d;
  wire is_sq   = (func == `OGS_FN_SQUARE);
  wire is_ramp = (func == `OGS_FN_RAMP);
  wire [1:0] new_rng = pwdata[`OGS_CTRL_RNG_HI:`OGS_CTRL_RNG_LO];

  // Clamp a duty into the window of the present frequency
  function [6:0] clamp_duty;
    input [7:0] req;
    input       high;
    reg   [7:0] lo;
    reg   [7:0] hi;
    begin
      lo = high ? {1'b0, `OGS_DUTY_MIN_HI} : {1'b0, `OGS_DUTY_MIN_LO};
      hi = high ? {1'b0, `OGS_DUTY_MAX_HI} : {1'b0, `OGS_DUTY_MAX_LO};
      if (req < lo) begin
        clamp_duty = lo[6:0];
      end else if (req > hi) begin
        clamp_duty = hi[6:0];
      end else begin
        clamp_duty = req[6:0];
      end
    end
  endfunction

  // Saturate so a large level never wraps small
  function [15:0] dbl_u;
    input [15:0] v;
    begin
      dbl_u = v[15] ? 16'hFFFF : {v[14:0], 1'b0};
    end
  endfunction

  function [15:0] dbl_s;
    input [15:0] v;
    begin
      if (v[15] != v[14]) begin
        dbl_s = v[15] ? 16'h8000 : 16'h7FFF;
      end else begin
        dbl_s = {v[14:0], 1'b0};
      end
    end
  endfunction

  always @* begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      `OGS_ADDR_CTRL: begin
        rd_word[`OGS_CTRL_OUT_EN]                    = out_en;
        rd_word[`OGS_CTRL_INVERT]                    = polarity_inv;
        rd_word[`OGS_CTRL_SYNC_EN]                   = sync_en;
        rd_word[`OGS_CTRL_HIZ]                       = term_hiz;
        rd_word[`OGS_CTRL_MARKER]                    = marker_en;
        rd_word[`OGS_CTRL_RNG_HI:`OGS_CTRL_RNG_LO]   = range_mode;
      end
      `OGS_ADDR_FUNC: begin
        rd_word[`OGS_FUNC_HI:`OGS_FUNC_LO] = func;
        rd_word[`OGS_MODE_HI:`OGS_MODE_LO] = mode;
      end
      `OGS_ADDR_DUTY:  rd_word[6:0]  = duty;
      `OGS_ADDR_SYMM:  rd_word[6:0]  = symm;
      `OGS_ADDR_AMPL:  rd_word[15:0] = ampl_disp;
      `OGS_ADDR_OFFS:  rd_word[15:0] = offs_disp;
      `OGS_ADDR_UNITS: rd_word[1:0]  = units;
      `OGS_ADDR_CMD:   rd_word       = 32'h0000_0000;
      `OGS_ADDR_STATUS: begin
        rd_word[`OGS_ST_OUT_ON]  = output_on;
        rd_word[`OGS_ST_FREQ_HI] = freq_high;
        rd_word[`OGS_ST_SYNC]    = sync_out;
        rd_word[`OGS_ST_HOLD]    = (range_mode == `OGS_RNG_OFF);
        rd_word[`OGS_ST_ERR_DBM] = err_dbm;
        rd_word[`OGS_ST_ERR_OVL] = err_ovl;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Registered bus outputs with no wait state: pready rises from the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~mapped;
      end
    end
  end

  always @* begin
    set_dbm = 1'b0;
    if (wr_unit && pwdata[1:0] == `OGS_UNIT_DBM && term_hiz) begin
      set_dbm = 1'b1;                                                           // [RULE_03]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_BOOT;
      term_hiz     <= 1'b0;
      sync_en      <= 1'b1;
      out_en       <= 1'b0;
      output_on    <= 1'b0;
      output_led   <= 1'b0;
      polarity_inv <= 1'b0;
      marker_en    <= 1'b0;
      range_mode   <= `OGS_RNG_ON;
      range_auto   <= 1'b1;
      range_select <= 1'b0;
      func         <= `OGS_FN_SINE;
      mode         <= `OGS_MD_CONT;
      duty         <= `OGS_DUTY_RST;
      symm         <= `OGS_SYMM_RST;
      wave_duty    <= `OGS_DUTY_RST;
      wave_symm    <= `OGS_SYMM_RST;
      mod_src_duty <= `OGS_DUTY_RST;
      mod_src_symm <= `OGS_SYMM_RST;
      ampl_disp    <= `OGS_AMPL_RST;
      offs_disp    <= `OGS_OFFS_RST;
      units        <= `OGS_UNIT_VPP;
      freq_high_d  <= 1'b0;
      err_dbm      <= 1'b0;
      err_ovl      <= 1'b0;
    end else if (ce) begin
      freq_high_d  <= freq_high;
      range_select <= 1'b0;
      case (state)
        ST_BOOT: begin
          // Stored settings come back without rescaling the levels
          term_hiz <= nv_term_hiz_in;                                           // [RULE_01]
          sync_en  <= nv_sync_en_in;                                            // [RULE_14]
          state    <= ST_RUN;
        end
        ST_RUN: begin
          if (wr_ctrl) begin
            polarity_inv <= pwdata[`OGS_CTRL_INVERT];                           // [RULE_12]
            sync_en      <= pwdata[`OGS_CTRL_SYNC_EN];                          // [RULE_14]
            marker_en    <= pwdata[`OGS_CTRL_MARKER];
            term_hiz     <= new_hiz;                                            // [RULE_01]
            out_en       <= pwdata[`OGS_CTRL_OUT_EN];
            if (new_rng == `OGS_RNG_ONCE) begin
              range_mode   <= `OGS_RNG_OFF;                                     // [RULE_10]
              range_select <= 1'b1;
            end else if (new_rng == `OGS_RNG_ON) begin
              range_mode <= `OGS_RNG_ON;
            end else begin
              range_mode <= `OGS_RNG_OFF;                                       // [RULE_10]
            end
          end
          if (hiz_chg) begin
            ampl_disp <= new_hiz ? dbl_u(ampl_disp) : {1'b0, ampl_disp[15:1]};  // [RULE_02]
            offs_disp <= new_hiz ? dbl_s(offs_disp) : {offs_disp[15], offs_disp[15:1]};
            if (new_hiz && units == `OGS_UNIT_DBM) begin
              units <= `OGS_UNIT_VPP;                                           // [RULE_03]
            end
          end else begin
            if (wr_ampl) begin
              ampl_disp <= pwdata[15:0];
            end
            if (wr_offs) begin
              offs_disp <= pwdata[15:0];
            end
          end
          if ((wr_ampl || wr_offs || hiz_chg) && range_mode == `OGS_RNG_ON) begin
            range_select <= 1'b1;                                               // [RULE_10]
          end
          if (wr_unit && !set_dbm && !hiz_chg) begin
            units <= pwdata[1:0];                                               // [RULE_03]
          end
          if (wr_func) begin
            func <= pwdata[`OGS_FUNC_HI:`OGS_FUNC_LO];
            mode <= pwdata[`OGS_MODE_HI:`OGS_MODE_LO];
          end
          if (wr_duty) begin
            duty <= clamp_duty(pwdata[7:0], freq_high);                         // [RULE_04]
          end else if (freq_high && is_sq && duty > `OGS_DUTY_MAX_HI) begin
            duty <= `OGS_DUTY_MAX_HI;                                           // [RULE_06]
          end else if (fh_rise && is_sq && duty < `OGS_DUTY_MIN_HI) begin
            duty <= `OGS_DUTY_MIN_HI;                                           // [RULE_04]
          end
          if (wr_symm) begin
            symm <= (pwdata[7:0] > {1'b0, `OGS_SYMM_MAX}) ? `OGS_SYMM_MAX : pwdata[6:0];
          end
          if (once) begin
            range_mode   <= `OGS_RNG_OFF;                                       // [RULE_10]
            range_select <= 1'b1;
          end
          if (rreset) begin
            // Termination and sync enable survive a remote reset
            duty         <= `OGS_DUTY_RST;                                      // [RULE_05]
            symm         <= `OGS_SYMM_RST;                                      // [RULE_09]
            units        <= `OGS_UNIT_VPP;
            out_en       <= 1'b0;                                               // [RULE_11]
            polarity_inv <= 1'b0;                                               // [RULE_12]
            range_mode   <= `OGS_RNG_ON;
            marker_en    <= 1'b0;
            func         <= `OGS_FN_SINE;
            mode         <= `OGS_MD_CONT;
          end
          if (apply) begin
            duty       <= `OGS_DUTY_RST;                                        // [RULE_08]
            symm       <= `OGS_SYMM_RST;                                        // [RULE_08]
            range_mode <= `OGS_RNG_ON;                                          // [RULE_08]
            out_en     <= 1'b1;                                                 // [RULE_08]
          end
          if (overload) begin
            out_en <= 1'b0;                                                     // [RULE_11]
          end
        end
        default: state <= ST_BOOT;
      endcase
      // Overload drops the output at once
      output_on  <= out_en & ~overload & (state == ST_RUN);                     // [RULE_11]
      output_led <= out_en & ~overload & (state == ST_RUN);                     // [RULE_11]
      range_auto <= (range_mode == `OGS_RNG_ON);                                // [RULE_10]
      // User shapes reach the carrier only, duty kept in the present window
      wave_duty    <= is_sq ? clamp_duty({1'b0, duty}, freq_high) : `OGS_DUTY_RST; // [RULE_07]
      wave_symm    <= is_ramp ? symm : `OGS_SYMM_RST;                           // [RULE_09]
      mod_src_duty <= `OGS_DUTY_RST;                                            // [RULE_07]
      mod_src_symm <= `OGS_SYMM_RST;                                            // [RULE_09]
      // Set beats a same-edge clear
      err_dbm <= set_dbm | (err_dbm & ~(wr_stat & pwdata[`OGS_ST_ERR_DBM]));    // [RULE_03]
      err_ovl <= (overload & out_en) |
                 (err_ovl & ~(wr_stat & pwdata[`OGS_ST_ERR_OVL]));              // [RULE_11]
    end
  end

  ogs_sync_gen u_sync (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .sync_en       (sync_en),
    .marker_en     (marker_en),
    .func          (func),
    .mode          (mode),
    .carrier_above (carrier_above),
    .arb_first     (arb_first),
    .arb_half      (arb_half),
    .mod_half      (mod_half),
    .fsk_hop       (fsk_hop),
    .sweep_start   (sweep_start),
    .sweep_mid     (sweep_mid),
    .marker_hit    (marker_hit),
    .burst_start   (burst_start),
    .burst_done    (burst_done),
    .gate_in       (gate_in),
    .cycle_end     (cycle_end),
    .sync_out      (sync_out)
  );

endmodule // ogs_output_setup

//--- dv/ogs_setup_checker.sv
/*
  Port checks of the output setup block, bound after the module.
  Assumes one pclk domain.
*/
`timescale 1ns/1ns

module ogs_setup_checker (
  input wire       pclk,
  input wire       presetn,
  input wire       freq_high,
  input wire       overload,
  input wire       output_on,
  input wire       output_led,
  input wire       term_hiz,
  input wire [6:0] wave_duty,
  input wire [6:0] wave_symm,
  input wire [6:0] mod_src_duty,
  input wire [6:0] mod_src_symm,
  input wire [1:0] units,
  input wire       range_select,
  input wire       sync_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_led_tracks_out: assert property (
    output_led == output_on) else $error("indicator differs from output");
  a_overload_kills_out: assert property (
    overload |-> ##[1:2] !output_on) else $error("output stays on in overload");
  a_duty_in_limits: assert property (
    wave_duty inside {[20:80]}) else $error("duty outside 20 to 80");
  a_duty_high_freq: assert property (
    freq_high [*3] |-> wave_duty inside {[40:60]}) else $error("duty not cut above 10 MHz");
  a_mod_src_fixed: assert property (
    mod_src_duty == 7'h32 && mod_src_symm == 7'h64) else $error("modulating shape changed");
  a_symm_bounded: assert property (
    wave_symm <= 7'h64) else $error("symmetry above 100");
  a_hiz_no_dbm: assert property (
    term_hiz && $past(term_hiz) |-> units != 2'h2) else $error("dBm kept at high Z");
  a_range_one_pulse: assert property (
    range_select |=> !range_select) else $error("range pick longer than a cycle");

  c_overload: cover property (overload ##2 !output_on);
  c_duty_cut: cover property (freq_high [*3] ##0 wave_duty == 7'h3C);
  c_sync_rise: cover property ($rose(sync_out));
  c_range_pick: cover property (range_select);
endmodule // ogs_setup_checker

bind ogs_output_setup ogs_setup_checker u_ogs_setup_checker (
  .pclk, .presetn, .freq_high, .overload, .output_on, .output_led, .term_hiz,
  .wave_duty, .wave_symm, .mod_src_duty, .mod_src_symm, .units, .range_select, .sync_out);

//--- dv/ogs_load_model.sv
/*
  Equipment on the output and sync pins: overload and gate source.
  Assumes the bench asks for overload, gate and cycles by level.
*/
`timescale 1ns/1ns

module ogs_load_model (
  input  wire pclk,
  input  wire presetn,
  input  wire ovl_req,
  input  wire gate_req,
  input  wire cyc_run,
  output reg  overload,
  output reg  gate_in,
  output reg  cycle_end
);
  reg [2:0] phase;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overload  <= 1'h0;
      gate_in   <= 1'h0;
      cycle_end <= 1'h0;
      phase     <= 3'h0;
    end else begin
      // Back-drive only on request
      overload  <= ovl_req;
      gate_in   <= gate_req;
      phase     <= phase + 3'h1;
      // One waveform cycle ends every eight clocks while running
      cycle_end <= cyc_run && (phase == 3'h7);
    end
  end
endmodule // ogs_load_model

//--- dv/testbench.sv
/*
  APB tasks and directed tests of the output setup block.
  Assumes stored low Z termination and sync enable on.
*/
`timescale 1ns/1ns

module testbench;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg         freq_high;
  reg         ovl_req;
  reg         gate_req;
  reg         cyc_run;
  reg  [15:0] ev;
  reg  [31:0] r;
  reg         e;
  integer     fails;
  integer     checked;
  wire        pready, pslverr, overload, gate_in, cycle_end;
  wire        output_on, output_led, term_hiz, sync_out;
  wire [31:0] prdata;
  wire [6:0]  wave_duty, wave_symm;

  ogs_output_setup u_ogs_output_setup (.pclk, .presetn, .ce(1'h1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .nv_term_hiz_in(1'h0),
    .nv_sync_en_in(1'h1), .freq_high, .overload, .carrier_above(ev[0]), .arb_first(ev[8]),
    .arb_half(ev[9]), .mod_half(ev[1]), .fsk_hop(ev[2]), .sweep_start(ev[3]),
    .sweep_mid(ev[4]), .marker_hit(ev[5]), .burst_start(ev[6]), .burst_done(ev[7]),
    .gate_in, .cycle_end, .output_on, .output_led, .polarity_inv(), .term_hiz,
    .sync_en(), .wave_duty, .wave_symm, .mod_src_duty(), .mod_src_symm(), .ampl_disp(),
    .offs_disp(), .units(), .range_auto(), .range_select(), .sync_out);
  ogs_load_model u_ogs_load_model (.pclk, .presetn, .ovl_req, .gate_req, .cyc_run,
    .overload, .gate_in, .cycle_end);

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task ck(input [8*10:1] nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task xfer(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'h1, d);
  endtask

  task rc(input [7:0] a, input [31:0] exp);
    begin
      xfer(a, 1'h0, 32'h0000_0000);
      ck("prdata", exp, r);
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask

  // Set, then clear; p: one-cycle pulses
  task sy(input [7:0] f, input [3:0] s, input [3:0] c, input p);
    begin
      wr(8'h04, f);
      @(posedge pclk) ev[s] <= 1'h1;
      @(posedge pclk) if (p) ev[s] <= 1'h0;
      tick(3);
      ck("sync_set", 1'h1, sync_out);
      @(posedge pclk) begin
        ev[s] <= 1'h0;
        ev[c] <= 1'h1;
      end
      @(posedge pclk) if (p) ev[c] <= 1'h0;
      tick(3);
      ck("sync_clr", 1'h0, sync_out);
    end
  endtask

  task report_and_stop;
    begin
      if (fails == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Run takes under 1000 cycles
  initial begin
    #100000;
    fails = fails + 1;
    report_and_stop;
  end

  initial begin
    fails = 0;
    checked = 0;
    {presetn, psel, penable, pwrite, freq_high, ovl_req, gate_req, cyc_run} = 8'h00;
    {paddr, pwdata, ev} = 56'h00_0000_0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    tick(2);
    rc(8'h00, 8'h24);
    rc(8'h08, 8'h32);
    rc(8'h0C, 8'h64);
    ck("output_on", 1'h0, output_on);
    rc(8'h40, 8'h00);
    ck("pslverr", 1'h1, e);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'h0A);
    rc(8'h08, 8'h14);
    wr(8'h08, 8'h5A);
    rc(8'h08, 8'h50);
    wr(8'h08, 8'h46);
    @(posedge pclk) freq_high <= 1'h1;
    tick(3);
    rc(8'h08, 8'h3C);
    ck("wave_duty", 8'h3C, wave_duty);
    @(posedge pclk) freq_high <= 1'h0;
    wr(8'h08, 8'h1E);
    wr(8'h0C, 8'h19);
    wr(8'h04, 8'h02);
    tick(3);
    ck("wave_duty", 8'h32, wave_duty);
    ck("wave_symm", 8'h19, wave_symm);
    rc(8'h08, 8'h1E);
    wr(8'h10, 16'h0100);
    wr(8'h14, 16'hFFF0);
    wr(8'h00, 8'h2C);
    rc(8'h10, 16'h0200);
    rc(8'h14, 16'hFFE0);
    wr(8'h18, 8'h02);
    rc(8'h18, 8'h00);
    rc(8'h20, 32'h0000_0100);
    wr(8'h1C, 8'h02);
    rc(8'h08, 8'h32);
    rc(8'h0C, 8'h64);
    ck("term_hiz", 1'h1, term_hiz);
    wr(8'h00, 8'h24);
    rc(8'h10, 16'h0100);
    wr(8'h00, 8'h04);
    wr(8'h08, 8'h1E);
    wr(8'h1C, 8'h01);
    tick(3);
    rc(8'h00, 8'h25);
    rc(8'h08, 8'h32);
    ck("output_led", 1'h1, output_led);
    @(posedge pclk) ovl_req <= 1'h1;
    tick(4);
    ck("output_on", 1'h0, output_on);
    @(posedge pclk) ovl_req <= 1'h0;
    rc(8'h20, 32'h0000_0300);
    wr(8'h00, 8'h26);
    sy(8'h00, 4'h0, 4'hF, 1'h0);
    sy(8'h04, 4'h8, 4'h9, 1'h1);
    sy(8'h10, 4'h1, 4'hF, 1'h0);
    sy(8'h20, 4'h0, 4'hF, 1'h0);
    sy(8'h30, 4'h2, 4'hF, 1'h0);
    sy(8'h40, 4'h3, 4'h4, 1'h1);
    sy(8'h50, 4'h6, 4'h7, 1'h1);
    sy(8'h60, 4'h0, 4'hF, 1'h0);
    wr(8'h00, 8'h30);
    sy(8'h40, 4'h3, 4'h5, 1'h1);
    wr(8'h00, 8'h20);
    wr(8'h04, 8'h00);
    @(posedge pclk) ev[0] <= 1'h1;
    tick(3);
    ck("sync_off", 1'h0, sync_out);
    wr(8'h00, 8'h24);
    wr(8'h04, 8'h05);
    tick(3);
    ck("sync_dc", 1'h0, sync_out);
    wr(8'h04, 8'h70);
    @(posedge pclk) gate_req <= 1'h1;
    tick(4);
    ck("sync_gate", 1'h1, sync_out);
    @(posedge pclk) gate_req <= 1'h0;
    tick(3);
    ck("sync_gate", 1'h1, sync_out);
    @(posedge pclk) cyc_run <= 1'h1;
    tick(12);
    ck("sync_gate", 1'h0, sync_out);
    report_and_stop;
  end
endmodule // testbench
